// ---- hdl/eabu_defs.svh ----
// constants of the eight-bit alu and branch unit
`ifndef EABU_DEFS_SVH
`define EABU_DEFS_SVH
// ----------------------------------------------------------------
// register map, byte addresses on the ahb-lite port
// ----------------------------------------------------------------
`define EABU_CTRL_OFS 8'h00
`define EABU_FLAGS_OFS 8'h04
`define EABU_PC_OFS 8'h08
`define EABU_SP_OFS 8'h0C
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EABU_CTRL_RST 1'h1
`define EABU_SP_RST 16'h01FF
`define EABU_FLAGS_RST 8'h00
// ----------------------------------------------------------------
// status_flags bit positions
// ----------------------------------------------------------------
`define EABU_FC 0
`define EABU_FZ 1
`define EABU_FN 2
`define EABU_FV 3
`define EABU_FS 4
`define EABU_FH 5
`define EABU_FT 6
`define EABU_FI 7
// ----------------------------------------------------------------
// instruction encoding: top nibble groups and sub codes
// ----------------------------------------------------------------
`define EABU_G_RR0 4'h0
`define EABU_G_RR1 4'h1
`define EABU_G_LOG 4'h2
`define EABU_G_CMPK 4'h3
`define EABU_G_DIFCI 4'h4
`define EABU_G_DIFI 4'h5
`define EABU_G_ORK 4'h6
`define EABU_G_ANDK 4'h7
`define EABU_G_MISC 4'h9
`define EABU_G_JREL 4'hC
`define EABU_G_CREL 4'hD
`define EABU_G_BIT 4'hF
`define EABU_M_JPTR 4'h4
`define EABU_M_CPTR 4'h5
`define EABU_M_WSUM 4'h6
`define EABU_M_WDIF 4'h7
`define EABU_M_IOD 4'h8
`define EABU_M_SIL 4'h9
`define EABU_M_IOR 4'hA
`define EABU_M_SIH 4'hB
`define EABU_JPTR_WORD 16'h9409
`define EABU_CPTR_WORD 16'h9509
// ----------------------------------------------------------------
// fixed register addresses
// ----------------------------------------------------------------
`define EABU_IMM_BASE 5'h10
`define EABU_WORD_BASE 5'h18
`define EABU_ZLO 5'h1E
`define EABU_ZHI 5'h1F
`endif

// ---- hdl/eabu_pkg.sv ----
// types of the eight-bit alu and branch unit
package eabu_pkg;
   // ----------------------------------------------------------------
   // decoded operation classes
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      op_none, op_sum, op_sumc, op_dif, op_difc, op_difi, op_difci,
      op_and, op_or, op_xor, op_andk, op_ork, op_cmp, op_cmpc, op_cmpk,
      op_eqsk, op_wsum, op_wdif, op_jrel, op_jptr, op_crel, op_cptr,
      op_bfh, op_bfl, op_srl, op_srh, op_sil, op_sih, op_ior, op_iod
   } eabu_op_t;
   // ----------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      st_run = 2'h0,
      st_last = 2'h1,
      st_push = 2'h3,
      st_idle = 2'h2
   } eabu_st_t;
endpackage

// ---- hdl/eabu_regfile.sv ----
// working register file, two registered read ports, one write port
`timescale 1ns/1ps
module eabu_regfile #(
   parameter int DW = 8,
   parameter int AW = 5
) (
   input wire logic hclk,
   input wire logic rd_en,
   input wire logic [AW-1:0] ra,
   input wire logic [AW-1:0] rb,
   input wire logic we,
   input wire logic [AW-1:0] wa,
   input wire logic [DW-1:0] wd,
   output logic [DW-1:0] qa,
   output logic [DW-1:0] qb
);
   logic [DW-1:0] mem [2**AW]; // storage, no reset

   // write port
   always_ff @(posedge hclk) begin
      if (we) begin
         mem[wa] <= wd;
      end
   end

   // read ports with write bypass, so a result is seen next cycle
   always_ff @(posedge hclk) begin
      if (rd_en) begin
         qa <= (we && wa == ra) ? wd : mem[ra];
         qb <= (we && wa == rb) ? wd : mem[rb];
      end
   end
endmodule

// ---- hdl/eabu_core.sv ----
// eight-bit alu and branch unit with ahb-lite control port
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "eabu_defs.svh"
module eabu_core
   import eabu_pkg::*;
#(
   parameter int PCW = 12 // program counter width in words
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [PCW-1:0] prog_addr,
   input wire logic [15:0] prog_data,
   output logic [4:0] io_addr,
   input wire logic [7:0] io_rdata,
   output logic io_we,
   output logic [7:0] io_wdata,
   output logic stack_we,
   output logic [15:0] stack_addr,
   output logic [7:0] stack_wdata
);
   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // instruction word to operation class
   function automatic eabu_op_t eabu_dec(input logic [15:0] w);
      eabu_op_t o;
      o = op_none;
      case (w[15:12])
         `EABU_G_RR0: o = (w[11:10] == 2'h1) ? op_cmpc :
            (w[11:10] == 2'h2) ? op_difc :
            (w[11:10] == 2'h3) ? op_sum : op_none;
         `EABU_G_RR1: o = (w[11:10] == 2'h0) ? op_eqsk :
            (w[11:10] == 2'h1) ? op_cmp :
            (w[11:10] == 2'h2) ? op_dif : op_sumc;
         `EABU_G_LOG: o = (w[11:10] == 2'h0) ? op_and :
            (w[11:10] == 2'h1) ? op_xor :
            (w[11:10] == 2'h2) ? op_or : op_none;
         `EABU_G_CMPK: o = op_cmpk;
         `EABU_G_DIFCI: o = op_difci;
         `EABU_G_DIFI: o = op_difi;
         `EABU_G_ORK: o = op_ork;
         `EABU_G_ANDK: o = op_andk;
         `EABU_G_JREL: o = op_jrel;
         `EABU_G_CREL: o = op_crel;
         // register bit skips: bit 9 picks polarity, bit 8 is a reg bit
         `EABU_G_BIT: o = !w[11] ? (w[10] ? op_bfl : op_bfh) :
            (!w[10] || w[3]) ? op_none :
            (w[9] ? op_srh : op_srl);
         `EABU_G_MISC: begin
            case (w[11:8])
               `EABU_M_JPTR: o = (w == `EABU_JPTR_WORD) ? op_jptr : op_none;
               `EABU_M_CPTR: o = (w == `EABU_CPTR_WORD) ? op_cptr : op_none;
               `EABU_M_WSUM: o = op_wsum;
               `EABU_M_WDIF: o = op_wdif;
               `EABU_M_IOD: o = op_iod;
               `EABU_M_SIL: o = op_sil;
               `EABU_M_IOR: o = op_ior;
               `EABU_M_SIH: o = op_sih;
               default: o = op_none;
            endcase
         end
         default: o = op_none;
      endcase
      return o;
   endfunction

   // operand addresses {first, second}; first is also the target
   function automatic logic [9:0] eabu_rfa(input logic [15:0] w);
      eabu_op_t o;
      logic [4:0] p;
      o = eabu_dec(w);
      p = `EABU_WORD_BASE | {2'h0, w[5:4], 1'b0};
      eabu_rfa = {w[8:4], w[9], w[3:0]};
      case (o)
         op_cmpk, op_difi, op_difci, op_andk, op_ork:
            eabu_rfa = {`EABU_IMM_BASE | {1'b0, w[7:4]}, 5'h0};
         op_wsum, op_wdif: eabu_rfa = {p, p | 5'h1};
         op_jptr, op_cptr: eabu_rfa = {`EABU_ZLO, `EABU_ZHI};
         default: ;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // state and wires
   // ----------------------------------------------------------------
   logic [15:0] instr_q; // instruction in execute
   logic valid_q; // instr_q holds a live instruction
   eabu_st_t state_q; // sequencer
   logic run_q; // software run enable
   logic [7:0] status_q; // status_flags
   logic [15:0] sp_q; // stack pointer
   logic [7:0] hi_q; // word result high byte
   logic [7:0] ret_hi_q; // return address high byte
   logic bw_q; // bus write in data phase
   logic [7:0] ba_q; // bus data phase address
   logic [7:0] qa, qb; // register operands
   eabu_op_t op;
   logic [9:0] dst;
   logic [2:0] bsel; // bit or flag index
   logic ex, fetch, multi, jmp, skip, tw, upd, wr, cin, is_k, bus_go;
   logic [7:0] opb, res, fl, rf_wd;
   logic [8:0] s9;
   logic [15:0] w16, kw;
   logic [PCW-1:0] tgt;
   logic rf_we;
   logic [4:0] rf_wa;
   logic [9:0] nxt_rfa; // operand addresses of the word on prog_data

   assign op = eabu_dec(instr_q);
   assign dst = eabu_rfa(instr_q);
   assign nxt_rfa = eabu_rfa(prog_data);
   assign bsel = instr_q[2:0];
   assign ex = run_q && state_q == st_run && valid_q;

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   // operands are fetched alongside the instruction word
   eabu_regfile #(.DW(8), .AW(5)) u_rf (
      .hclk(hclk),
      .rd_en(fetch),
      .ra(nxt_rfa[9:5]),
      .rb(nxt_rfa[4:0]),
      .we(rf_we),
      .wa(rf_wa),
      .wd(rf_wd),
      .qa(qa),
      .qb(qb)
   );

   // low byte with flags first, high byte in the second clock
   assign rf_we = (ex && wr) || (run_q && state_q == st_last
      && op inside {op_wsum, op_wdif});
   assign rf_wa = (state_q == st_last) ? dst[4:0] : dst[9:5];
   assign rf_wd = (state_q == st_last) ? hi_q : res;

   // ----------------------------------------------------------------
   // alu
   // ----------------------------------------------------------------
   assign is_k = op inside {op_cmpk, op_difi, op_difci, op_andk, op_ork};
   assign opb = is_k ? {instr_q[11:8], instr_q[3:0]} : qb;
   assign cin = status_q[`EABU_FC]
      & (op inside {op_sumc, op_difc, op_difci, op_cmpc});
   assign kw = {10'h0, instr_q[7:6], instr_q[3:0]};
   assign w16 = (op == op_wsum) ? {qb, qa} + kw : {qb, qa} - kw;

   // result and new flags of the executing instruction
   always_comb begin
      s9 = 9'h0;
      res = 8'h0;
      fl = status_q;
      upd = 1'b0;
      wr = 1'b0;
      unique case (op)
         op_sum, op_sumc: begin
            s9 = {1'b0, qa} + {1'b0, opb} + {8'h0, cin};
            res = s9[7:0];
            fl[`EABU_FH] = qa[3] & opb[3] | opb[3] & ~res[3] | ~res[3] & qa[3];
            fl[`EABU_FV] = qa[7] & opb[7] & ~res[7] | ~qa[7] & ~opb[7] & res[7];
            fl[`EABU_FC] = s9[8];
            upd = 1'b1;
            wr = 1'b1;
         end
         // compares share the subtractor but keep the register
         op_dif, op_difc, op_difi, op_difci, op_cmp, op_cmpc, op_cmpk: begin
            s9 = {1'b0, qa} - {1'b0, opb} - {8'h0, cin};
            res = s9[7:0];
            fl[`EABU_FH] = ~qa[3] & opb[3] | opb[3] & res[3] | res[3] & ~qa[3];
            fl[`EABU_FV] = qa[7] & ~opb[7] & ~res[7] | ~qa[7] & opb[7] & res[7];
            fl[`EABU_FC] = s9[8];
            upd = 1'b1;
            wr = !(op inside {op_cmp, op_cmpc, op_cmpk});
         end
         // bit clear and test are and forms, carry untouched
         op_and, op_andk, op_or, op_ork, op_xor: begin
            res = (op == op_xor) ? qa ^ opb :
               (op inside {op_or, op_ork}) ? qa | opb : qa & opb;
            fl[`EABU_FV] = 1'b0;
            upd = 1'b1;
            wr = 1'b1;
         end
         op_wsum, op_wdif: begin
            res = w16[7:0];
            fl[`EABU_FV] = (op == op_wsum) ? ~qb[7] & w16[15] : qb[7] & ~w16[15];
            fl[`EABU_FC] = (op == op_wsum) ? qb[7] & ~w16[15] : w16[15] & ~qb[7];
            upd = 1'b1;
            wr = 1'b1;
         end
         default: ;
      endcase
      if (upd) begin
         fl[`EABU_FN] = (op inside {op_wsum, op_wdif}) ? w16[15] : res[7];
         // chained borrow forms only keep zero if it was already set
         fl[`EABU_FZ] = (op inside {op_wsum, op_wdif}) ? (w16 == 16'h0) :
            (res == 8'h0) & (!(op inside {op_difc, op_difci, op_cmpc})
            | status_q[`EABU_FZ]);
         fl[`EABU_FS] = fl[`EABU_FN] ^ fl[`EABU_FV];
      end
   end

   // ----------------------------------------------------------------
   // flow control decisions
   // ----------------------------------------------------------------
   // a skipped two-word instruction costs one more clock
   assign tw = (prog_data[15:10] == 6'h24 && prog_data[3:0] == 4'h0)
      || (prog_data[15:9] == 7'h4A && prog_data[3:2] == 2'h3);

   // branches index the flags; signed ones use the s flag (n ^ v)
   always_comb begin
      jmp = 1'b0;
      skip = 1'b0;
      tgt = prog_addr;
      unique case (op)
         op_jrel, op_crel: begin
            jmp = 1'b1;
            tgt = prog_addr + PCW'({{4{instr_q[11]}}, instr_q[11:0]});
         end
         op_jptr, op_cptr: begin
            jmp = 1'b1;
            tgt = PCW'({qb, qa});
         end
         op_bfh, op_bfl: begin
            jmp = status_q[bsel] ^ (op == op_bfl);
            tgt = prog_addr + PCW'({{9{instr_q[9]}}, instr_q[9:3]});
         end
         op_eqsk: skip = qa == qb;
         op_srl, op_srh: skip = qa[bsel] ^ (op == op_srl);
         op_sil, op_sih: skip = io_rdata[bsel] ^ (op == op_sil);
         default: ;
      endcase
   end

   assign multi = op inside {op_wsum, op_wdif, op_ior, op_iod};
   assign fetch = run_q && (state_q == st_last || (state_q == st_run
      && (!valid_q || !(multi || jmp || skip))));

   // ----------------------------------------------------------------
   // sequencer: program counter, instruction register, state
   // ----------------------------------------------------------------
   // program_counter is the fetch address, one past instr_q
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prog_addr <= '0;
         instr_q <= 16'h0;
         valid_q <= 1'b0;
         state_q <= st_run;
         io_addr <= 5'h0;
      end else if (fetch) begin
         instr_q <= prog_data;
         valid_q <= 1'b1;
         prog_addr <= prog_addr + 1'b1;
         io_addr <= prog_data[7:3];
         state_q <= st_run;
      end else if (ex) begin
         if (multi) begin
            state_q <= st_last;
         end else if (jmp) begin
            prog_addr <= tgt;
            valid_q <= 1'b0;
            if (op inside {op_crel, op_cptr}) begin
               state_q <= st_push;
            end
         end else if (skip) begin
            prog_addr <= prog_addr + (tw ? PCW'(2) : PCW'(1));
            valid_q <= 1'b0;
            if (tw) begin
               state_q <= st_idle;
            end
         end
      end else if (run_q && state_q != st_run) begin
         state_q <= st_run;
      end
   end

   // high byte of a word result waits one clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hi_q <= 8'h0;
      end else if (ex) begin
         hi_q <= w16[15:8];
      end
   end

   // ----------------------------------------------------------------
   // status_flags: core update wins over a bus write
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_q <= `EABU_FLAGS_RST;
      end else if (ex && upd) begin
         status_q <= fl;
      end else if (bw_q && ba_q == `EABU_FLAGS_OFS) begin
         status_q <= hwdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // stack pushes of the return address, low byte first
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stack_we <= 1'b0;
         stack_addr <= 16'h0;
         stack_wdata <= 8'h0;
         ret_hi_q <= 8'h0;
         sp_q <= `EABU_SP_RST;
      end else begin
         stack_we <= 1'b0;
         if (ex && op inside {op_crel, op_cptr}) begin
            stack_we <= 1'b1;
            stack_addr <= sp_q;
            stack_wdata <= 8'(prog_addr);
            ret_hi_q <= 8'(prog_addr >> 8);
            sp_q <= sp_q - 16'h1;
         end else if (run_q && state_q == st_push) begin
            stack_we <= 1'b1;
            stack_addr <= sp_q;
            stack_wdata <= ret_hi_q;
            sp_q <= sp_q - 16'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // i/o single bit write, read-modify-write of one port register
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         io_we <= 1'b0;
         io_wdata <= 8'h0;
      end else begin
         io_we <= ex && op inside {op_ior, op_iod};
         if (ex && op inside {op_ior, op_iod}) begin
            io_wdata <= (op == op_ior) ? io_rdata | (8'h1 << bsel)
               : io_rdata & ~(8'h1 << bsel);
         end
      end
   end

   // ----------------------------------------------------------------
   // ahb-lite slave: zero wait states, always okay
   // ----------------------------------------------------------------
   assign bus_go = hsel && hready && htrans[1];

   // read data is taken in the address phase, so a read right after
   // a write to the same register returns the old value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bw_q <= 1'b0;
         ba_q <= 8'h0;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         bw_q <= bus_go && hwrite && haddr[31:8] == 24'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (bus_go) begin
            ba_q <= haddr[7:0];
            hrdata <= 32'h0;
            if (!hwrite && haddr[31:8] == 24'h0) begin
               case (haddr[7:0])
                  `EABU_CTRL_OFS: hrdata <= {31'h0, run_q};
                  `EABU_FLAGS_OFS: hrdata <= {24'h0, status_q};
                  `EABU_PC_OFS: hrdata <= 32'(prog_addr);
                  `EABU_SP_OFS: hrdata <= {16'h0, sp_q};
                  default: hrdata <= 32'h0;
               endcase
            end
         end
      end
   end

   // run enable freezes the whole sequencer when low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_q <= `EABU_CTRL_RST;
      end else if (bw_q && ba_q == `EABU_CTRL_OFS) begin
         run_q <= hwdata[0];
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sum_result_a:
      assert property (ex && op == op_sum |-> rf_we && rf_wd == 8'(qa + qb))
      else $error("sum result not written");
   word_two_clk_a:
      assert property (ex && op inside {op_wsum, op_wdif} |=>
         state_q == st_last && rf_we ##1 state_q == st_run && valid_q)
      else $error("word op not two clocks");
   diff_borrow_a:
      assert property (ex && op == op_dif |=>
         status_q[`EABU_FC] == ($past(qa) < $past(qb)))
      else $error("borrow flag wrong");
   logic_carry_a:
      assert property (ex && op inside {op_and, op_or, op_xor, op_andk,
         op_ork} |=> $stable(status_q[`EABU_FC]) && !status_q[`EABU_FV])
      else $error("logic op changed carry");
   test_keep_a:
      assert property (ex && op == op_and && dst[9:5] == dst[4:0] |->
         rf_wd == qa)
      else $error("self and altered value");
   goto_two_clk_a:
      assert property (ex && op == op_jrel |=>
         !valid_q && prog_addr == $past(tgt) ##1 valid_q)
      else $error("relative goto timing");
   call_push_a:
      assert property (ex && op == op_crel |=> stack_we ##1 stack_we
         ##1 !stack_we && valid_q)
      else $error("call push sequence");
   skip_equal_a:
      assert property (ex && op == op_eqsk && qa == qb |=> !valid_q)
      else $error("equal skip missed");
   reg_bit_skip_a:
      assert property (ex && op == op_srl && !qa[bsel] && !tw |=>
         !valid_q && prog_addr == $past(prog_addr) + 1'b1)
      else $error("register bit skip missed");
   compare_quiet_a:
      assert property (ex && op inside {op_cmp, op_cmpc, op_cmpk} |-> !rf_we)
      else $error("compare wrote register");
   branch_miss_a:
      assert property (ex && op == op_bfh && !status_q[bsel] |=>
         valid_q && prog_addr == $past(prog_addr) + 1'b1)
      else $error("untaken branch not one clock");
   io_bit_two_a:
      assert property (ex && op == op_ior |=> io_we
         ##1 !io_we && valid_q)
      else $error("io bit write timing");

   call_seen_c: cover property (ex && op == op_crel ##3 valid_q);
   word_seen_c: cover property (ex && op == op_wdif);
   skip_seen_c: cover property (ex && skip && tw);
endmodule

// ---- tb/eabu_far_model.sv ----
// program memory, i/o registers and stack memory facing the core
`timescale 1ns/1ps
module eabu_far_model (
   input wire logic hclk,
   input wire logic [11:0] prog_addr,
   output logic [15:0] prog_data,
   input wire logic [4:0] io_addr,
   output logic [7:0] io_rdata,
   input wire logic io_we,
   input wire logic [7:0] io_wdata,
   input wire logic stack_we,
   input wire logic [15:0] stack_addr,
   input wire logic [7:0] stack_wdata
);
   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [15:0] rom [0:15]; // program words, rest loops on itself
   logic [7:0] io_q [0:31]; // i/o register file
   logic [7:0] stk_q [0:511]; // stack bytes
   int io_writes; // count of i/o write pulses
   // asynchronous read, same cycle as the address
   assign prog_data = (prog_addr < 16) ? rom[prog_addr[3:0]] : 16'hCFFF;
   assign io_rdata = io_q[io_addr];
   // writes land on the rising edge, one byte per pulse
   always @(posedge hclk) begin
      if (io_we === 1'b1) begin
         io_q[io_addr] <= io_wdata;
         io_writes <= io_writes + 1;
      end
      if (stack_we === 1'b1) begin
         stk_q[stack_addr[8:0]] <= stack_wdata;
      end
   end
   initial begin
      io_writes = 0;
      for (int i = 0; i < 32; i++) io_q[i] = 8'h41;
      for (int i = 0; i < 16; i++) rom[i] = 16'hCFFF;
      rom[0] = 16'h7000; // mask r16 with zero
      rom[1] = 16'h6800; // or in the sign bit
      rom[2] = 16'h3800; // compare equal
      rom[3] = 16'h5001; // subtract one, signed overflow
      rom[4] = 16'hF00B; // branch on overflow over next word
      rom[5] = 16'h6F0F; // poison: must be skipped
      rom[6] = 16'h9A2A; // raise bit 2 of i/o register 5
      rom[7] = 16'hD000; // call next word
      rom[8] = 16'hFD07; // r16 bit 7 is clear: skip next word
      rom[9] = 16'h9A22; // poison: would raise bit 2 of i/o register 4
   end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench: runs a short program, inspects state over ahb
`timescale 1ns/1ps
module tb_top;
   import eabu_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic hreadyout, hresp, io_we, stack_we;
   logic [11:0] prog_addr;
   logic [15:0] prog_data, stack_addr;
   logic [4:0] io_addr;
   logic [7:0] io_rdata, io_wdata, stack_wdata;
   int miscompares = 0, samples_checked = 0, cyc = 0;
   always #50 hclk = ~hclk; // 10 MHz
   eabu_core u_eabu_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .prog_addr(prog_addr),
      .prog_data(prog_data), .io_addr(io_addr), .io_rdata(io_rdata),
      .io_we(io_we), .io_wdata(io_wdata), .stack_we(stack_we),
      .stack_addr(stack_addr), .stack_wdata(stack_wdata));
   eabu_far_model u_eabu_far_model (.hclk(hclk), .prog_addr(prog_addr),
      .prog_data(prog_data), .io_addr(io_addr), .io_rdata(io_rdata),
      .io_we(io_we), .io_wdata(io_wdata), .stack_we(stack_we),
      .stack_addr(stack_addr), .stack_wdata(stack_wdata));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one single ahb-lite word transfer, waits on hready each phase
   task automatic xfer(input logic w, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // hang guard, far beyond the roughly seventy cycles needed
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         miscompares++;
         finish_test();
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, 32'h0, 32'h0, rd); chk(rd, 32'h1);
      xfer(1'b0, 32'hC, 32'h0, rd); chk(rd, 32'h01FF);
      repeat (40) @(posedge hclk);
      // program has settled in its final self loop
      xfer(1'b0, 32'h4, 32'h0, rd); chk(rd, 32'h38);
      xfer(1'b0, 32'h8, 32'h0, rd); chk(rd, 32'hA);
      xfer(1'b0, 32'hC, 32'h0, rd); chk(rd, 32'h01FD);
      chk(u_eabu_far_model.stk_q[9'h1FF], 32'h8);
      chk(u_eabu_far_model.stk_q[9'h1FE], 32'h0);
      chk(u_eabu_far_model.io_q[5], 32'h45);
      chk(u_eabu_far_model.io_q[4], 32'h41);
      chk(u_eabu_far_model.io_writes, 32'h1);
      xfer(1'b1, 32'h4, 32'h01, rd);
      xfer(1'b0, 32'h4, 32'h0, rd); chk(rd, 32'h01);
      xfer(1'b0, 32'h40, 32'h0, rd); chk(rd, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      finish_test();
   end
endmodule
